// >>> src/tdc_codec.sv
// format conversion between channel bytes and tape characters
`timescale 1ns/100ps
`include "tdc_regs.svh"
`default_nettype none
module tdc_codec (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // option strap and order
    input wire logic pack_option,
    input wire logic order_valid,
    input wire logic [7:0] order_byte,
    // write path: bytes from the io_channel_processor
    input wire logic wr_byte_valid,
    output logic wr_byte_ready,
    input wire tdc_pkg::tdc_byte_t wr_byte,
    // write path: characters to tape
    output logic wr_char_valid,
    input wire logic wr_char_ready,
    output tdc_pkg::tdc_char_t wr_char,
    // read path: characters from tape (last marks the lrc character)
    input wire logic rd_char_valid,
    output logic rd_char_ready,
    input wire tdc_pkg::tdc_char_t rd_char,
    // read path: bytes to the io_channel_processor
    output logic rd_byte_valid,
    input wire logic rd_byte_ready,
    output tdc_pkg::tdc_byte_t rd_byte,
    // status
    output logic busy,
    output logic order_reject,
    output logic data_error,
    output logic tape_mark,
    output logic rec_done
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WRITE = 4'b0010,
        ST_READ = 4'b0100,
        ST_FLUSH = 4'b1000
    } tdc_state_t;

    // parity bit for a character under the given mode: even in BCD mode, odd in binary and packed
    function automatic logic par_bit(input logic [5:0] c, input tdc_pkg::tdc_mode_t m);
        par_bit = (m == tdc_pkg::TDC_MODE_BCD) ? ^c : ~(^c);
    endfunction

    function automatic logic [5:0] ebc_to_bcd(input logic [7:0] e);
        case (e)
            8'hc1: ebc_to_bcd = 6'o61; 8'hc2: ebc_to_bcd = 6'o62; 8'hc3: ebc_to_bcd = 6'o63;
            8'hc4: ebc_to_bcd = 6'o64; 8'hc5: ebc_to_bcd = 6'o65; 8'hc6: ebc_to_bcd = 6'o66;
            8'hc7: ebc_to_bcd = 6'o67; 8'hc8: ebc_to_bcd = 6'o70; 8'hc9: ebc_to_bcd = 6'o71;
            8'hd1: ebc_to_bcd = 6'o41; 8'hd2: ebc_to_bcd = 6'o42; 8'hd3: ebc_to_bcd = 6'o43;
            8'hd4: ebc_to_bcd = 6'o44; 8'hd5: ebc_to_bcd = 6'o45; 8'hd6: ebc_to_bcd = 6'o46;
            8'hd7: ebc_to_bcd = 6'o47; 8'hd8: ebc_to_bcd = 6'o50; 8'hd9: ebc_to_bcd = 6'o51;
            8'he2: ebc_to_bcd = 6'o22; 8'he3: ebc_to_bcd = 6'o23; 8'he4: ebc_to_bcd = 6'o24;
            8'he5: ebc_to_bcd = 6'o25; 8'he6: ebc_to_bcd = 6'o26; 8'he7: ebc_to_bcd = 6'o27;
            8'he8: ebc_to_bcd = 6'o30; 8'he9: ebc_to_bcd = 6'o31;
            `TDC_EBC_ZERO, `TDC_EBC_ALT_ZERO: ebc_to_bcd = `TDC_BCD_ZERO;
            8'hf1: ebc_to_bcd = 6'o01; 8'hf2: ebc_to_bcd = 6'o02; 8'hf3: ebc_to_bcd = 6'o03;
            8'hf4: ebc_to_bcd = 6'o04; 8'hf5: ebc_to_bcd = 6'o05; 8'hf6: ebc_to_bcd = 6'o06;
            8'hf7: ebc_to_bcd = 6'o07; 8'hf8: ebc_to_bcd = 6'o10; 8'hf9: ebc_to_bcd = 6'o11;
            8'h40: ebc_to_bcd = 6'o20; 8'h4a: ebc_to_bcd = 6'o72; 8'h4b: ebc_to_bcd = 6'o73;
            8'h4c: ebc_to_bcd = 6'o74; 8'h4d: ebc_to_bcd = 6'o75; 8'h4e: ebc_to_bcd = 6'o76;
            8'h4f: ebc_to_bcd = 6'o77; 8'h50: ebc_to_bcd = 6'o60; 8'h5a: ebc_to_bcd = 6'o52;
            8'h5b: ebc_to_bcd = 6'o53; 8'h5c: ebc_to_bcd = 6'o54; 8'h5d: ebc_to_bcd = 6'o55;
            8'h5e: ebc_to_bcd = 6'o56; 8'h5f: ebc_to_bcd = 6'o57; 8'h60: ebc_to_bcd = 6'o40;
            8'h61: ebc_to_bcd = 6'o21; 8'h6a: ebc_to_bcd = 6'o32; 8'h6b: ebc_to_bcd = 6'o33;
            8'h6c: ebc_to_bcd = 6'o34; 8'h6d: ebc_to_bcd = 6'o35; 8'h6e: ebc_to_bcd = 6'o36;
            8'h6f: ebc_to_bcd = 6'o37; 8'h7b: ebc_to_bcd = 6'o13; 8'h7c: ebc_to_bcd = 6'o14;
            8'h7d: ebc_to_bcd = 6'o15; 8'h7e: ebc_to_bcd = 6'o16; 8'h7f: ebc_to_bcd = 6'o17;
            default: ebc_to_bcd = `TDC_UNDEF_CHAR;
        endcase
    endfunction

    function automatic logic [7:0] bcd_to_ebc(input logic [5:0] b);
        case (b)
            6'o61: bcd_to_ebc = 8'hc1; 6'o62: bcd_to_ebc = 8'hc2; 6'o63: bcd_to_ebc = 8'hc3;
            6'o64: bcd_to_ebc = 8'hc4; 6'o65: bcd_to_ebc = 8'hc5; 6'o66: bcd_to_ebc = 8'hc6;
            6'o67: bcd_to_ebc = 8'hc7; 6'o70: bcd_to_ebc = 8'hc8; 6'o71: bcd_to_ebc = 8'hc9;
            6'o41: bcd_to_ebc = 8'hd1; 6'o42: bcd_to_ebc = 8'hd2; 6'o43: bcd_to_ebc = 8'hd3;
            6'o44: bcd_to_ebc = 8'hd4; 6'o45: bcd_to_ebc = 8'hd5; 6'o46: bcd_to_ebc = 8'hd6;
            6'o47: bcd_to_ebc = 8'hd7; 6'o50: bcd_to_ebc = 8'hd8; 6'o51: bcd_to_ebc = 8'hd9;
            6'o22: bcd_to_ebc = 8'he2; 6'o23: bcd_to_ebc = 8'he3; 6'o24: bcd_to_ebc = 8'he4;
            6'o25: bcd_to_ebc = 8'he5; 6'o26: bcd_to_ebc = 8'he6; 6'o27: bcd_to_ebc = 8'he7;
            6'o30: bcd_to_ebc = 8'he8; 6'o31: bcd_to_ebc = 8'he9;
            `TDC_BCD_ZERO: bcd_to_ebc = `TDC_EBC_ZERO;
            6'o01: bcd_to_ebc = 8'hf1; 6'o02: bcd_to_ebc = 8'hf2; 6'o03: bcd_to_ebc = 8'hf3;
            6'o04: bcd_to_ebc = 8'hf4; 6'o05: bcd_to_ebc = 8'hf5; 6'o06: bcd_to_ebc = 8'hf6;
            6'o07: bcd_to_ebc = 8'hf7; 6'o10: bcd_to_ebc = 8'hf8; 6'o11: bcd_to_ebc = 8'hf9;
            6'o20: bcd_to_ebc = 8'h40; 6'o72: bcd_to_ebc = 8'h4a; 6'o73: bcd_to_ebc = 8'h4b;
            6'o74: bcd_to_ebc = 8'h4c; 6'o75: bcd_to_ebc = 8'h4d; 6'o76: bcd_to_ebc = 8'h4e;
            6'o77: bcd_to_ebc = 8'h4f; 6'o60: bcd_to_ebc = 8'h50; 6'o52: bcd_to_ebc = 8'h5a;
            6'o53: bcd_to_ebc = 8'h5b; 6'o54: bcd_to_ebc = 8'h5c; 6'o55: bcd_to_ebc = 8'h5d;
            6'o56: bcd_to_ebc = 8'h5e; 6'o57: bcd_to_ebc = 8'h5f; 6'o40: bcd_to_ebc = 8'h60;
            6'o21: bcd_to_ebc = 8'h61; 6'o32: bcd_to_ebc = 8'h6a; 6'o33: bcd_to_ebc = 8'h6b;
            6'o34: bcd_to_ebc = 8'h6c; 6'o35: bcd_to_ebc = 8'h6d; 6'o36: bcd_to_ebc = 8'h6e;
            6'o37: bcd_to_ebc = 8'h6f; 6'o13: bcd_to_ebc = 8'h7b; 6'o14: bcd_to_ebc = 8'h7c;
            6'o15: bcd_to_ebc = 8'h7d; 6'o16: bcd_to_ebc = 8'h7e; 6'o17: bcd_to_ebc = 8'h7f;
            default: bcd_to_ebc = `TDC_UNDEF_BYTE;
        endcase
    endfunction

    tdc_state_t state_ff;
    tdc_pkg::tdc_mode_t mode_ff;
    logic mark_ff;
    logic [23:0] acc_ff;
    logic [1:0] cnt_ff;
    logic [1:0] rem_ff;
    logic [5:0] lrc_ff;
    logic [5:0] rd_cnt_ff;
    logic only_mark_ff;
    logic busy_ff;
    logic reject_ff;
    logic derr_ff;
    logic tmark_ff;
    logic done_ff;
    logic last_seen_ff;
    // write-side character source feeding the output fifo
    logic wc_valid;
    logic wc_ready;
    tdc_pkg::tdc_char_t wc;
    // read-side byte source feeding the output fifo
    logic rb_valid;
    logic rb_ready;
    tdc_pkg::tdc_byte_t rb;
    logic ord_ok;
    logic is_wr;
    tdc_pkg::tdc_mode_t ord_mode;
    logic [5:0] wr_conv;
    logic wr_take;
    logic rd_take;
    logic fifo_wc_valid;
    logic fifo_rb_valid;
    tdc_pkg::tdc_char_t fifo_wc;
    tdc_pkg::tdc_byte_t fifo_rb;
    logic rd_mode_ff;

    // flush belongs to the read path after a read order, else to the write path
    function automatic logic is_rd_flush();
        is_rd_flush = (state_ff == ST_FLUSH) && mark_ff == 1'b0 && rd_mode_ff;
    endfunction

    // order decode
    always_comb begin
        ord_ok = 1'b1;
        is_wr = 1'b0;
        ord_mode = tdc_pkg::TDC_MODE_BINARY;
        case (order_byte)
            `TDC_ORD_WR_BINARY: is_wr = 1'b1;
            `TDC_ORD_WR_MARK: begin
                is_wr = 1'b1;
                ord_mode = tdc_pkg::TDC_MODE_BCD;
            end
            `TDC_ORD_WR_BCD: begin
                is_wr = 1'b1;
                ord_mode = tdc_pkg::TDC_MODE_BCD;
            end
            `TDC_ORD_WR_PACKED: begin
                is_wr = 1'b1;
                ord_mode = tdc_pkg::TDC_MODE_PACKED;
                ord_ok = pack_option;
            end
            `TDC_ORD_RD_BINARY: ord_ok = 1'b1;
            `TDC_ORD_RD_BCD: ord_mode = tdc_pkg::TDC_MODE_BCD;
            `TDC_ORD_RD_PACKED: begin
                ord_mode = tdc_pkg::TDC_MODE_PACKED;
                ord_ok = pack_option;
            end
            default: ord_ok = 1'b0;
        endcase
    end

    // write-side byte to character
    assign wr_conv = (mode_ff == tdc_pkg::TDC_MODE_BCD) ? ebc_to_bcd(wr_byte.data)
                                                         : wr_byte.data[5:0];
    always_comb begin
        wc_valid = 1'b0;
        wc.data = wr_conv;
        wc.last = wr_byte.last;
        if (state_ff == ST_FLUSH) begin
            wc_valid = !is_rd_flush();
            wc.data = acc_ff[23:18];
            wc.last = (rem_ff == 2'd1) || (rem_ff == 2'd0 && cnt_ff == 2'd3 && last_seen_ff);
        end else if (state_ff == ST_WRITE && mark_ff) begin
            wc_valid = 1'b1;
            wc.data = `TDC_TAPE_MARK_CHAR;
            wc.last = 1'b1;
        end else if (state_ff == ST_WRITE && mode_ff != tdc_pkg::TDC_MODE_PACKED) begin
            wc_valid = wr_byte_valid;
        end
        wc.parity = par_bit(wc.data, mode_ff);
    end
    assign wr_take = (state_ff == ST_WRITE) && !mark_ff && wr_byte_valid &&
                     ((mode_ff == tdc_pkg::TDC_MODE_PACKED) || wc_ready);
    assign wr_byte_ready = wr_take;

    // read-side character to byte
    assign rd_take = (state_ff == ST_READ) && rd_char_valid &&
                     ((mode_ff == tdc_pkg::TDC_MODE_PACKED) || rd_char.last || rb_ready);
    assign rd_char_ready = rd_take;
    always_comb begin
        rb_valid = 1'b0;
        rb.data = (mode_ff == tdc_pkg::TDC_MODE_BCD) ? bcd_to_ebc(rd_char.data)
                                                      : {2'b00, rd_char.data};
        rb.last = 1'b0;
        if (state_ff == ST_FLUSH) begin
            rb_valid = is_rd_flush();
            rb.data = acc_ff[23:16];
            rb.last = (rem_ff == 2'd1);
        end else if (state_ff == ST_READ && mode_ff != tdc_pkg::TDC_MODE_PACKED) begin
            rb_valid = rd_char_valid && !rd_char.last;
        end
    end

    // sequencing, mode latch and packing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            mode_ff <= tdc_pkg::TDC_MODE_BINARY;
            mark_ff <= 1'b0;
            acc_ff <= 24'h000000;
            cnt_ff <= 2'd0;
            rem_ff <= 2'd0;
            last_seen_ff <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (order_valid && ord_ok) begin
                        mode_ff <= ord_mode;
                        mark_ff <= (order_byte == `TDC_ORD_WR_MARK);
                        acc_ff <= 24'h000000;
                        cnt_ff <= 2'd0;
                        state_ff <= is_wr ? ST_WRITE : ST_READ;
                    end
                end
                ST_WRITE: begin
                    if (mark_ff && wc_ready) begin
                        state_ff <= ST_IDLE;
                    end else if (wr_take && mode_ff != tdc_pkg::TDC_MODE_PACKED) begin
                        if (wr_byte.last) begin
                            state_ff <= ST_IDLE;
                        end
                    end else if (wr_take) begin
                        acc_ff <= (cnt_ff == 2'd0) ? {wr_byte.data, 16'h0000} :
                                  (cnt_ff == 2'd1) ? {acc_ff[23:16], wr_byte.data, 8'h00} :
                                                     {acc_ff[23:8], wr_byte.data};
                        if (cnt_ff == 2'd2 || wr_byte.last) begin
                            rem_ff <= (cnt_ff == 2'd2) ? 2'd0 : cnt_ff + 2'd2;
                            cnt_ff <= 2'd0;
                            last_seen_ff <= wr_byte.last;
                            state_ff <= ST_FLUSH;
                        end else begin
                            cnt_ff <= cnt_ff + 2'd1;
                        end
                    end
                end
                ST_READ: begin
                    if (rd_take && rd_char.last) begin
                        if (mode_ff == tdc_pkg::TDC_MODE_PACKED && cnt_ff != 2'd0) begin
                            rem_ff <= cnt_ff;
                            last_seen_ff <= 1'b1;
                            state_ff <= ST_FLUSH;
                        end else begin
                            state_ff <= ST_IDLE;
                        end
                    end else if (rd_take && mode_ff == tdc_pkg::TDC_MODE_PACKED) begin
                        acc_ff <= acc_ff | ({rd_char.data, 18'h00000} >> (6 * cnt_ff));
                        if (cnt_ff == 2'd3) begin
                            rem_ff <= 2'd3;
                            cnt_ff <= 2'd0;
                            last_seen_ff <= 1'b0;
                            state_ff <= ST_FLUSH;
                        end else begin
                            cnt_ff <= cnt_ff + 2'd1;
                        end
                    end
                end
                ST_FLUSH: begin
                    if (is_rd_flush() ? rb_ready : wc_ready) begin
                        acc_ff <= is_rd_flush() ? {acc_ff[15:0], 8'h00} : {acc_ff[17:0], 6'h00};
                        if (rem_ff == 2'd1 || (!is_rd_flush() && rem_ff == 2'd0 && cnt_ff == 2'd3)) begin
                            acc_ff <= 24'h000000;
                            cnt_ff <= 2'd0;
                            state_ff <= (last_seen_ff || is_rd_flush()) ? (last_seen_ff ? ST_IDLE : ST_READ)
                                                                        : ST_WRITE;
                        end else begin
                            rem_ff <= (rem_ff == 2'd0) ? 2'd0 : rem_ff - 2'd1;
                            cnt_ff <= cnt_ff + 2'd1;
                        end
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_mode_ff <= 1'b0;
        end else if (state_ff == ST_IDLE && order_valid && ord_ok) begin
            rd_mode_ff <= !is_wr;
        end
    end

    // read checks: vertical and longitudinal parity, tape mark
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lrc_ff <= 6'h00;
            rd_cnt_ff <= 6'h00;
            only_mark_ff <= 1'b1;
            derr_ff <= 1'b0;
            tmark_ff <= 1'b0;
        end else if (state_ff == ST_IDLE && order_valid && ord_ok) begin
            lrc_ff <= 6'h00;
            rd_cnt_ff <= 6'h00;
            only_mark_ff <= 1'b1;
            derr_ff <= 1'b0;
            tmark_ff <= 1'b0;
        end else if (rd_take) begin
            if (rd_char.parity != par_bit(rd_char.data, mode_ff)) begin
                derr_ff <= 1'b1;
            end
            if (rd_char.last) begin
                if ((lrc_ff ^ rd_char.data) != 6'h00) begin
                    derr_ff <= 1'b1;
                end
                tmark_ff <= only_mark_ff && (rd_cnt_ff == 6'h01);
            end else begin
                lrc_ff <= lrc_ff ^ rd_char.data;
                rd_cnt_ff <= (rd_cnt_ff == 6'h3f) ? rd_cnt_ff : rd_cnt_ff + 6'h01;
                if (rd_char.data != `TDC_TAPE_MARK_CHAR) begin
                    only_mark_ff <= 1'b0;
                end
            end
        end
    end

    // status outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_ff <= 1'b0;
            reject_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            busy_ff <= (state_ff != ST_IDLE);
            reject_ff <= (state_ff == ST_IDLE) && order_valid && !ord_ok;
            done_ff <= busy_ff && (state_ff == ST_IDLE);
        end
    end
    assign busy = busy_ff;
    assign order_reject = reject_ff;
    assign data_error = derr_ff;
    assign tape_mark = tmark_ff;
    assign rec_done = done_ff;

    // output buffering
    tdc_fifo #(.WIDTH($bits(tdc_pkg::tdc_char_t)), .DEPTH(`TDC_FIFO_DEPTH)) u_wr_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(wc_valid),
        .in_ready(wc_ready),
        .in_data(wc),
        .out_valid(fifo_wc_valid),
        .out_ready(wr_char_ready),
        .out_data(fifo_wc)
    );
    tdc_fifo #(.WIDTH($bits(tdc_pkg::tdc_byte_t)), .DEPTH(`TDC_FIFO_DEPTH)) u_rd_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(rb_valid),
        .in_ready(rb_ready),
        .in_data(rb),
        .out_valid(fifo_rb_valid),
        .out_ready(rd_byte_ready),
        .out_data(fifo_rb)
    );
    assign wr_char_valid = fifo_wc_valid;
    assign wr_char = fifo_wc;
    assign rd_byte_valid = fifo_rb_valid;
    assign rd_byte = fifo_rb;
endmodule // tdc_codec
`default_nettype wire

// >>> src/tdc_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module tdc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_ff;
    logic [AW-1:0] rp_ff;
    logic [AW:0] cnt_ff;
    logic push;
    logic pop;
    assign in_ready = (cnt_ff != DEPTH[AW:0]);
    assign out_valid = (cnt_ff != '0);
    assign out_data = mem[rp_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_ff] <= in_data;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wp_ff <= wp_ff + 1'b1;
            end
            if (pop) begin
                rp_ff <= rp_ff + 1'b1;
            end
            if (push && !pop) begin
                cnt_ff <= cnt_ff + 1'b1;
            end else if (pop && !push) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end
endmodule // tdc_fifo
`default_nettype wire

// >>> src/tdc_pkg.sv
// types for the tape data format codec
package tdc_pkg;
    typedef enum logic [1:0] {
        TDC_MODE_BINARY = 2'h0,
        TDC_MODE_BCD = 2'h1,
        TDC_MODE_PACKED = 2'h2
    } tdc_mode_t;
    typedef struct packed {
        logic [7:0] data;
        logic last;
    } tdc_byte_t;
    typedef struct packed {
        logic [5:0] data;
        logic parity;
        logic last;
    } tdc_char_t;
endpackage

// >>> src/tdc_regs.svh
// constants for the tape data format codec
`ifndef TDC_REGS_SVH
`define TDC_REGS_SVH
`define TDC_ORD_RD_PACKED 8'h02
`define TDC_ORD_RD_BINARY 8'h06
`define TDC_ORD_RD_BCD 8'h0e
`define TDC_ORD_WR_PACKED 8'h01
`define TDC_ORD_WR_BINARY 8'h05
`define TDC_ORD_WR_BCD 8'h0d
`define TDC_ORD_WR_MARK 8'h73
`define TDC_TAPE_MARK_CHAR 6'h0f
`define TDC_BCD_ZERO 6'h0a
`define TDC_EBC_ZERO 8'hf0
`define TDC_EBC_ALT_ZERO 8'h7a
`define TDC_UNDEF_CHAR 6'h00
`define TDC_UNDEF_BYTE 8'h00
`define TDC_FIFO_DEPTH 8
`endif

// >>> verification/tb.sv
// self-checking bench for the format codec
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk, rst_n, pack_option, order_valid, wr_byte_valid, wr_byte_ready, wr_char_valid, wr_char_ready;
    logic rd_char_valid, rd_char_ready, rd_byte_valid, rd_byte_ready, busy, order_reject, data_error, seen;
    logic tape_mark, rec_done;
    logic [7:0] order_byte;
    tdc_pkg::tdc_byte_t wr_byte, rd_byte;
    tdc_pkg::tdc_char_t wr_char, rd_char;
    logic [7:0] ebc[5] = '{8'hf0, 8'h7a, 8'hc1, 8'h40, 8'h05};
    logic [5:0] bcd[5] = '{6'h0a, 6'h0a, 6'h31, 6'h10, 6'h00};
    logic [6:0] exp_c[$];
    logic [7:0] exp_b[$];
    int miscompares, samples_checked, cycles;
    tdc_codec uut (.clk(clk), .rst_n(rst_n), .pack_option(pack_option), .order_valid(order_valid),
        .order_byte(order_byte), .wr_byte_valid(wr_byte_valid), .wr_byte_ready(wr_byte_ready), .wr_byte(wr_byte),
        .wr_char_valid(wr_char_valid), .wr_char_ready(wr_char_ready), .wr_char(wr_char),
        .rd_char_valid(rd_char_valid), .rd_char_ready(rd_char_ready), .rd_char(rd_char),
        .rd_byte_valid(rd_byte_valid), .rd_byte_ready(rd_byte_ready), .rd_byte(rd_byte), .busy(busy),
        .order_reject(order_reject), .data_error(data_error), .tape_mark(tape_mark), .rec_done(rec_done));
    tdc_far_model u_far (.clk(clk), .rst_n(rst_n), .char_ready(wr_char_ready), .byte_ready(rd_byte_ready));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic cmp_c(logic [6:0] e, logic [6:0] s);
        samples_checked++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH char exp %h got %h", e, s);
        end
    endtask
    task automatic cmp_v(string what, logic [7:0] e, logic [7:0] s);
        samples_checked++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", what, e, s);
        end
    endtask
    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic pulse_order(logic [7:0] o);
        order_valid = 1'b1;
        order_byte = o;
        @(negedge clk);
        order_valid = 1'b0;
    endtask
    task automatic settle(logic [7:0] o);
        seen = 1'b0;
        while (busy !== 1'b0 || exp_c.size() + exp_b.size() > 0) begin
            seen |= rec_done;
            @(negedge clk);
        end
        seen |= rec_done;
        cmp_v("rec_done", 8'h01, {7'h0, seen});
        repeat (2) @(negedge clk);
        $display("test with order %h done", o);
    endtask
    task automatic wr_rec(logic [7:0] o, int n);
        logic [7:0] d[6];
        logic [47:0] acc;
        int nc;
        acc = '0;
        for (int i = 0; i < n; i++) begin
            d[i] = (o == 8'h0d) ? ebc[i] : 8'($urandom);
            acc = {acc[39:0], d[i]};
            if (o == 8'h05) exp_c.push_back({d[i][5:0], ~^d[i][5:0]});
            if (o == 8'h0d) exp_c.push_back({bcd[i], ^bcd[i]});
        end
        nc = (8 * n + 5) / 6;
        acc = acc << (6 * nc - 8 * n);
        for (int k = nc - 1; o == 8'h01 && k >= 0; k--) exp_c.push_back({acc[6*k +: 6], ~^acc[6*k +: 6]});
        if (o == 8'h73) exp_c.push_back({6'h0f, 1'b0});
        pulse_order(o);
        for (int i = 0; i < n; i++) begin
            if (i == 1) begin
                wr_byte_valid = 1'b0;
                pulse_order(8'hff);
            end
            wr_byte_valid = 1'b1;
            wr_byte = '{data: d[i], last: i == n - 1};
            @(posedge clk);
            while (wr_byte_ready !== 1'b1) @(posedge clk);
            @(negedge clk);
        end
        wr_byte_valid = 1'b0;
        settle(o);
    endtask
    task automatic rd_rec(logic [7:0] o, int n, logic bad);
        logic [5:0] c[9];
        logic [47:0] acc;
        int nb;
        acc = '0;
        c[n] = {5'h0, bad};
        for (int i = 0; i < n; i++) begin
            c[i] = (o == 8'h0e) ? bcd[i ? i + 1 : 0] : (n == 1) ? 6'h0f : 6'($urandom);
            acc = {acc[41:0], c[i]};
            c[n] ^= c[i];
            if (o == 8'h06) exp_b.push_back({2'h0, c[i]});
            if (o == 8'h0e) exp_b.push_back(ebc[i ? i + 1 : 0]);
        end
        nb = (6 * n + 7) / 8;
        acc = acc << (8 * nb - 6 * n);
        for (int k = nb - 1; o == 8'h02 && k >= 0; k--) exp_b.push_back(acc[8*k +: 8]);
        pulse_order(o);
        for (int i = 0; i <= n; i++) begin
            rd_char_valid = 1'b1;
            rd_char = '{data: c[i], parity: (o == 8'h0e) ? ^c[i] : ~^c[i], last: i == n};
            @(posedge clk);
            while (rd_char_ready !== 1'b1) @(posedge clk);
            @(negedge clk);
        end
        rd_char_valid = 1'b0;
        settle(o);
        cmp_v("data_error", {7'h0, bad}, {7'h0, data_error});
        cmp_v("tape_mark", {7'h0, n == 1}, {7'h0, tape_mark});
    endtask
    always @(posedge clk) begin
        cycles++;
        if (wr_char_valid && wr_char_ready) cmp_c(exp_c.pop_front(), {wr_char.data, wr_char.parity});
        if (rd_byte_valid && rd_byte_ready) cmp_v("byte", exp_b.pop_front(), rd_byte.data);
        if (cycles > 20000) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        {rst_n, order_valid, order_byte, wr_byte_valid, wr_byte, rd_char_valid, rd_char} = '0;
        pack_option = 1'b1;
        seen = 1'b0;
        void'($urandom(84));
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        wr_rec(8'h05, 4);
        wr_rec(8'h0d, 5);
        for (int n = 3; n <= 5; n++) wr_rec(8'h01, n);
        wr_rec(8'h73, 0);
        rd_rec(8'h06, 4, 1'b0);
        rd_rec(8'h06, 1, 1'b0);
        rd_rec(8'h0e, 3, 1'b1);
        for (int n = 5; n <= 8; n++) rd_rec(8'h02, n, 1'b0);
        pack_option = 1'b0;
        pulse_order(8'h02);
        repeat (2) begin
            seen |= order_reject;
            @(negedge clk);
        end
        cmp_v("order_reject", 8'h01, {7'h0, seen});
        report_and_stop();
    end
endmodule // tb
`default_nettype wire

// >>> verification/tdc_codec_chk.sv
// assertions on the codec ports
`timescale 1ns/100ps
`default_nettype none
module tdc_codec_chk (
    // clock, reset, order
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pack_option,
    input wire logic order_valid,
    input wire logic [7:0] order_byte,
    // data outputs
    input wire logic wr_char_valid,
    input wire tdc_pkg::tdc_char_t wr_char,
    input wire logic rd_byte_valid,
    input wire tdc_pkg::tdc_byte_t rd_byte,
    // status
    input wire logic busy,
    input wire logic order_reject,
    input wire logic data_error
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] ord_ff;
    logic take;
    logic bcd;
    logic odd;
    assign take = order_valid && !busy;
    assign bcd = ord_ff[3:2] == 2'h3;
    assign odd = ord_ff[7:4] == 4'h0 && !bcd;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            ord_ff <= 8'h00;
        else if (take)
            ord_ff <= order_byte;
    end
    sequence s_pk_off;
        take && !pack_option && (order_byte == 8'h01 || order_byte == 8'h02);
    endsequence
    odd_par_a: assert property (wr_char_valid && odd |-> wr_char.parity == ~^wr_char.data)
        else $error("odd parity wrong");
    even_par_a: assert property (wr_char_valid && bcd |-> wr_char.parity == ^wr_char.data)
        else $error("even parity wrong");
    top_zero_a: assert property (rd_byte_valid && ord_ff[3:2] == 2'h1 |-> rd_byte.data[7:6] == 2'h0)
        else $error("binary read top bits set");
    no_alt_zero_a: assert property (rd_byte_valid && bcd |-> rd_byte.data != 8'h7a)
        else $error("alternate zero read back");
    pack_off_a: assert property (s_pk_off |-> ##[1:2] order_reject)
        else $error("packed order not refused");
    order_busy_a: assert property (take && order_byte inside {8'h05, 8'h06, 8'h0d, 8'h0e} |-> ##[1:2] busy)
        else $error("order did not start");
    busy_ignore_a: assert property (order_valid && busy |-> ##1 !order_reject [*2])
        else $error("order taken while busy");
    err_busy_a: assert property ($rose(data_error) |-> busy || $past(busy))
        else $error("data error outside a read");
endmodule // tdc_codec_chk
bind tdc_codec tdc_codec_chk u_chk (.clk(clk), .rst_n(rst_n), .pack_option(pack_option),
    .order_valid(order_valid), .order_byte(order_byte), .wr_char_valid(wr_char_valid), .wr_char(wr_char),
    .rd_byte_valid(rd_byte_valid), .rd_byte(rd_byte), .busy(busy), .order_reject(order_reject),
    .data_error(data_error));
`default_nettype wire

// >>> verification/tdc_far_model.sv
// far side sinks that stall at random
`timescale 1ns/100ps
`default_nettype none
module tdc_far_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // sink readies
    output logic char_ready,
    output logic byte_ready
);
    always @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            char_ready <= 1'b0;
            byte_ready <= 1'b0;
        end else begin
            char_ready <= $urandom_range(3) != 0;
            byte_ready <= $urandom_range(3) != 0;
        end
    end
endmodule // tdc_far_model
`default_nettype wire
